// *** verilog/sgps_cfg.svh ***
// Register map, field positions and reset values of the group selector.
// Assumes inclusion by the package, the selector top and the bench only.
`ifndef SGPS_CFG_SVH
`define SGPS_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define SGPS_A_CTRL    8'h00
`define SGPS_A_REMOTE  8'h04
`define SGPS_A_LOCAL   8'h08
`define SGPS_A_STATUS  8'h0c
`define SGPS_A_RISE_EN 8'h10
`define SGPS_A_FALL_EN 8'h14
`define SGPS_A_TIME    8'h18
`define SGPS_A_EVPOP   8'h1c
`define SGPS_A_EVRISE  8'h20
`define SGPS_A_EVFALL  8'h24
`define SGPS_A_EVTIME  8'h28

// ==========================================================
// Control, target and overflow fields
`define SGPS_USED_MSB  2
`define SGPS_USED_LSB  0
`define SGPS_FEN_BIT   3
`define SGPS_FGRP_MSB  7
`define SGPS_FGRP_LSB  4
`define SGPS_TGT_MSB   3
`define SGPS_TGT_LSB   0
`define SGPS_TGT_MAX   4'h8
`define SGPS_OVF_BIT   27

// ==========================================================
// Event status vector layout
`define SGPS_EV_W      30
`define SGPS_EV_ENA    0
`define SGPS_EV_REQ    8
`define SGPS_EV_ACT    16
`define SGPS_EV_REM    24
`define SGPS_EV_LOC    25
`define SGPS_EV_FRC    26
`define SGPS_EV_FNC    27
`define SGPS_EV_FFR    28
`define SGPS_EV_FPR    29
`define SGPS_STAT_RST  30'h00010001
`define SGPS_EVEN_RST  30'h3fffffff

`endif

// *** verilog/sgps_pkg.sv ***
// Types shared by the group selector, its checker and its bench.
// Assumes the constants header is on the include path.
`include "sgps_cfg.svh"

package sgps_pkg;
   typedef logic [2:0]              sgps_group_t;
   typedef logic [3:0]              sgps_target_t;
   typedef logic [`SGPS_EV_W-1:0]   sgps_evvec_t;
endpackage : sgps_pkg

// *** verilog/sgps_event_ram.sv ***
// Event buffer storage: one write port, one registered read port.
// Assumes a single clock and a clock enable from the selector.
`timescale 1ns/100ps

module sgps_event_ram
#(
   parameter int WIDTH = 92,
   parameter int AW    = 4
)
(
   input  wire logic             clk,
   input  wire logic             ce,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (we)
            mem[waddr] <= wdata;
         rdata <= mem[raddr];
      end
   end
endmodule : sgps_event_ram

// *** verilog/sgps_selector.sv ***
// Eight-way setting group priority selector with APB registers and a
// time-stamped event buffer.
// Assumes group_req comes from pins or other clocks; APB on pclk.
`timescale 1ns/100ps
`include "sgps_cfg.svh"

module sgps_selector
#(
   parameter int EV_AW = 4,
   parameter int TS_W  = 32
)
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [7:0]           group_req,
   output sgps_pkg::sgps_group_t     active_group
);
   import sgps_pkg::*;

   localparam int EVW = `SGPS_EV_W;
   localparam int MW  = 2 * EVW + TS_W;

   // ==========================================================
   // Helpers
   function automatic logic [3:0] first_set(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--)
         if (v[i])
            r = {1'b1, 3'(i)};
      return r;
   endfunction : first_set

   function automatic logic [7:0] onehot(input sgps_group_t g);
      return 8'h01 << g;
   endfunction : onehot

   function automatic logic [7:0] upto(input sgps_group_t n);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++)
         m[i] = (3'(i) <= n);
      return m;
   endfunction : upto

   function automatic sgps_group_t tgt_idx(input sgps_target_t t);
      return 3'(t - 4'h1);
   endfunction : tgt_idx

   // ==========================================================
   // Registers and state
   logic [7:0]             req_s1;
   logic [7:0]             req_s2;
   sgps_group_t            used_count;
   logic                   force_en;
   sgps_target_t           force_group;
   logic                   remote_pulse;
   logic                   local_pulse;
   sgps_target_t           remote_tgt;
   sgps_target_t           local_tgt;
   sgps_evvec_t            rise_en;
   sgps_evvec_t            fall_en;
   sgps_evvec_t            prev_stat;
   logic [TS_W-1:0]        tstamp;
   logic                   overflow;
   logic [EV_AW-1:0]       wr_ptr;
   logic [EV_AW-1:0]       rd_ptr;
   logic [EV_AW:0]         ev_count;
   logic                   rd_wait;
   logic                   pop_ok;
   sgps_evvec_t            ev_rise;
   sgps_evvec_t            ev_fall;
   logic [TS_W-1:0]        ev_time;
   logic [MW-1:0]          ram_q;

   // ==========================================================
   // Request resolution
   wire [7:0]        used_mask   = upto(used_count);
   wire [7:0]        valid_req   = req_s2 & used_mask;
   wire [7:0]        bad_req     = req_s2 & ~used_mask;
   wire [3:0]        lvl_enc     = first_set(valid_req);
   wire              lvl_hit     = lvl_enc[3];
   wire sgps_group_t lvl_idx     = lvl_enc[2:0];
   // Winner is the highest held level; all lower ones wait
   wire              lvl_blocked = lvl_hit &&
                     ((valid_req & ~onehot(lvl_idx)) != 8'h00);

   wire              soft_valid  = remote_pulse | local_pulse;
   wire sgps_target_t soft_tgt   = remote_pulse ? remote_tgt : local_tgt;
   wire sgps_group_t soft_idx    = tgt_idx(soft_tgt);
   wire              soft_in_use = soft_valid && (soft_tgt != 4'h0) &&
                                   (soft_tgt <= `SGPS_TGT_MAX) &&
                                   used_mask[soft_idx];
   // A held level of equal or higher priority keeps control
   wire              soft_apply  = soft_in_use &&
                                   (!lvl_hit || soft_idx < lvl_idx);
   wire              soft_reject = soft_in_use && !soft_apply;

   wire              frc_on      = force_en && (force_group != 4'h0);
   wire sgps_group_t frc_idx     = tgt_idx(force_group);
   wire              frc_ok      = frc_on && used_mask[frc_idx] &&
                                   (force_group <= `SGPS_TGT_MAX);
   wire              frc_fail    = frc_on && !frc_ok;

   wire              fail_nc     = (bad_req != 8'h00) ||
                                   (soft_valid && !soft_in_use);
   wire              fail_prio   = !frc_on &&
                                   (lvl_blocked || soft_reject);
   // Levels re-evaluate each cycle; absence of any request holds the
   // last choice, so a pulse-chosen group stays
   wire sgps_group_t auto_idx    = soft_apply ? soft_idx :
                                   lvl_hit    ? lvl_idx  :
                                   active_group;
   // Unless force is on, shrinking the used set drops a stale choice back to group one
   wire sgps_group_t next_active =
      frc_on ? (frc_ok ? frc_idx : active_group) :
      !used_mask[auto_idx] ? 3'h0 : auto_idx;

   // ==========================================================
   // Event detection
   wire sgps_evvec_t stat = {fail_prio, frc_fail, fail_nc, frc_on,
                             local_pulse, remote_pulse,
                             onehot(active_group), req_s2, used_mask};
   wire sgps_evvec_t rise_sel = stat & ~prev_stat & rise_en;
   wire sgps_evvec_t fall_sel = ~stat & prev_stat & fall_en;
   wire              ev_any   = (rise_sel | fall_sel) != '0;
   wire              ev_full  = ev_count[EV_AW];
   wire              ev_push  = ev_any && !ev_full;
   // Time stamp taken in the same cycle the status changed
   wire [MW-1:0]     ev_word  = {tstamp, fall_sel, rise_sel};

   // ==========================================================
   // APB decode
   wire acc      = psel & penable;
   wire wr_fire  = acc & pwrite;
   wire rd_done  = acc & ~pwrite & rd_wait;
   wire sel_ctrl = paddr == `SGPS_A_CTRL;
   wire sel_rem  = paddr == `SGPS_A_REMOTE;
   wire sel_loc  = paddr == `SGPS_A_LOCAL;
   wire sel_stat = paddr == `SGPS_A_STATUS;
   wire sel_rise = paddr == `SGPS_A_RISE_EN;
   wire sel_fall = paddr == `SGPS_A_FALL_EN;
   wire sel_time = paddr == `SGPS_A_TIME;
   wire sel_pop  = paddr == `SGPS_A_EVPOP;
   wire sel_evr  = paddr == `SGPS_A_EVRISE;
   wire sel_evf  = paddr == `SGPS_A_EVFALL;
   wire sel_evt  = paddr == `SGPS_A_EVTIME;
   wire addr_ok  = sel_ctrl | sel_rem | sel_loc | sel_stat | sel_rise |
                   sel_fall | sel_time | sel_pop | sel_evr | sel_evf |
                   sel_evt;
   wire ev_pop   = rd_done & sel_pop & pop_ok;
   wire ovf_clr  = wr_fire & sel_stat & pwdata[`SGPS_OVF_BIT];

   // Reads take one wait cycle so the data comes from a flip-flop
   assign pready  = pwrite | rd_wait;
   assign pslverr = acc & pready & ~addr_ok;

   wire [31:0] ctrl_rd = {24'h0, force_group, force_en, used_count};
   wire [31:0] stat_rd = {4'h0, overflow, fail_prio, frc_fail, fail_nc,
                          used_mask, req_s2, 5'h0, active_group};
   wire [31:0] pop_rd  = {26'h0, ev_count, (ev_count != '0)};
   wire [31:0] rd_mux  =
      sel_ctrl ? ctrl_rd :
      sel_stat ? stat_rd :
      sel_rise ? 32'(rise_en) :
      sel_fall ? 32'(fall_en) :
      sel_time ? 32'(tstamp) :
      sel_pop  ? pop_rd :
      sel_evr  ? 32'(ev_rise) :
      sel_evf  ? 32'(ev_fall) :
      sel_evt  ? 32'(ev_time) :
      32'h0;

   // ==========================================================
   // Pin synchronisers and selection state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_s1 <= 8'h00;
         req_s2 <= 8'h00;
      end
      else if (ce)
      begin
         req_s1 <= group_req;
         req_s2 <= req_s1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         active_group <= 3'h0;
      else if (ce)
         active_group <= next_active;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         used_count  <= 3'h0;
         force_en    <= 1'b0;
         force_group <= 4'h0;
         rise_en     <= `SGPS_EVEN_RST;
         fall_en     <= `SGPS_EVEN_RST;
      end
      else if (ce)
      begin
         if (wr_fire && sel_ctrl)
         begin
            used_count  <= pwdata[`SGPS_USED_MSB:`SGPS_USED_LSB];
            force_en    <= pwdata[`SGPS_FEN_BIT];
            force_group <= pwdata[`SGPS_FGRP_MSB:`SGPS_FGRP_LSB];
         end
         if (wr_fire && sel_rise)
            rise_en <= pwdata[EVW-1:0];
         if (wr_fire && sel_fall)
            fall_en <= pwdata[EVW-1:0];
      end
   end

   // Remote and local changes are single-cycle requests
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         remote_pulse <= 1'b0;
         local_pulse  <= 1'b0;
         remote_tgt   <= 4'h0;
         local_tgt    <= 4'h0;
      end
      else if (ce)
      begin
         remote_pulse <= wr_fire && sel_rem &&
                         pwdata[`SGPS_TGT_MSB:`SGPS_TGT_LSB] != 4'h0;
         local_pulse  <= wr_fire && sel_loc &&
                         pwdata[`SGPS_TGT_MSB:`SGPS_TGT_LSB] != 4'h0;
         if (wr_fire && sel_rem)
            remote_tgt <= pwdata[`SGPS_TGT_MSB:`SGPS_TGT_LSB];
         if (wr_fire && sel_loc)
            local_tgt <= pwdata[`SGPS_TGT_MSB:`SGPS_TGT_LSB];
      end
   end

   // ==========================================================
   // Event buffer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_stat <= `SGPS_STAT_RST;
         tstamp    <= '0;
         overflow  <= 1'b0;
      end
      else if (ce)
      begin
         prev_stat <= stat;
         tstamp    <= tstamp + 1'b1;
         // A new loss outranks a clear in the same cycle
         if (ev_any && ev_full)
            overflow <= 1'b1;
         else if (ovf_clr)
            overflow <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         ev_count <= '0;
      end
      else if (ce)
      begin
         if (ev_push)
            wr_ptr <= wr_ptr + 1'b1;
         if (ev_pop)
            rd_ptr <= rd_ptr + 1'b1;
         ev_count <= ev_count + (EV_AW+1)'(ev_push) -
                     (EV_AW+1)'(ev_pop);
      end
   end

   sgps_event_ram
   #(
      .WIDTH (MW),
      .AW    (EV_AW)
   )
   u_ram
   (
      .clk   (pclk),
      .ce    (ce),
      .we    (ev_push),
      .waddr (wr_ptr),
      .wdata (ev_word),
      .raddr (rd_ptr),
      .rdata (ram_q)
   );

   // ==========================================================
   // Read path
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_wait <= 1'b0;
         pop_ok  <= 1'b0;
         prdata  <= 32'h0;
      end
      else if (ce)
      begin
         rd_wait <= acc & ~pwrite & ~rd_wait;
         if (acc && !pwrite && !rd_wait)
         begin
            prdata <= rd_mux;
            // Emptiness judged before a same-cycle push lands
            pop_ok <= ev_count != '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ev_rise <= '0;
         ev_fall <= '0;
         ev_time <= '0;
      end
      else if (ce && ev_pop)
      begin
         ev_rise <= ram_q[EVW-1:0];
         ev_fall <= ram_q[2*EVW-1:EVW];
         ev_time <= ram_q[MW-1:2*EVW];
      end
   end
endmodule : sgps_selector

// *** verif/sgps_req_src.sv ***
// Far-side model: input pins and user logic driving group requests.
// Assumes the bench asks for levels and one-cycle pulse strobes.
`timescale 1ns/100ps

module sgps_req_src
(
   input  wire logic       pclk,
   input  wire logic [7:0] lvl,
   input  wire logic [7:0] pls,
   output logic      [7:0] group_req
);
   logic [7:0] p1 = 8'h00;
   logic [7:0] p2 = 8'h00;

   // Pulses last three cycles, above the two-cycle sync minimum
   always @(posedge pclk)
   begin
      p1        <= pls;
      p2        <= p1;
      group_req <= lvl | pls | p1 | p2;
   end
endmodule : sgps_req_src

// *** verif/sgps_selector_chk.sv ***
// Checker for the group selector: APB timing, priority and force.
// Assumes a bind to the top; CTRL is shadowed from observed writes.
`timescale 1ns/100ps

module sgps_selector_chk
(
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  ce,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [7:0]            paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic [7:0]            group_req,
   input wire sgps_pkg::sgps_group_t active_group
);
   import sgps_pkg::*;

   function automatic logic [2:0] first(input logic [7:0] v);
      logic [2:0] i;
      i = 3'h0;
      for (int k = 7; k >= 0; k--)
         if (v[k])
            i = 3'(k);
      return i;
   endfunction : first

   // ======================================================
   // Shadow of CTRL: used count and force are not at the ports
   logic [2:0] used_r;
   logic       fen_r;
   logic [3:0] fgrp_r;
   wire        ctl_wr = ce && psel && penable && pwrite && paddr == 8'h00;
   wire        any_wr = psel && pwrite;
   wire [7:0]  used_m = 8'((16'h2 << used_r) - 16'h1);
   wire [7:0]  live = group_req & used_m;
   wire        frc = fen_r && fgrp_r != 4'h0;
   wire        frc_ok = frc && fgrp_r <= {1'b0, used_r} + 4'h1;
   wire [2:0]  win = first(live);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         used_r <= 3'h0;
         fen_r  <= 1'b0;
         fgrp_r <= 4'h0;
      end
      else if (ctl_wr)
      begin
         used_r <= pwdata[2:0];
         fen_r  <= pwdata[3];
         fgrp_r <= pwdata[7:4];
      end
   end

   // ======================================================
   // Properties
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_write_nowait: assert property (psel && penable && pwrite |-> pready)
      else $error("write not ready in first access cycle");
   a_read_wait: assert property
      (psel && penable && !pwrite && !$past(penable) |-> !pready)
      else $error("read ready without wait cycle");
   a_read_done: assert property
      (psel && penable && !pwrite && !pready |=> pready)
      else $error("read wait longer than one cycle");
   a_err_unmapped: assert property
      (psel && penable && pready && paddr > 8'h28 |-> pslverr)
      else $error("unmapped access without error");
   a_reset_group: assert property
      ($rose(presetn) |-> active_group == 3'h0)
      else $error("group one not active after reset");
   a_held_one: assert property
      ((ce && !frc && group_req[0]) [*3] |=> active_group == 3'h0)
      else $error("held group one not active");
   a_held_prio: assert property
      ((ce && !frc && !any_wr && live != 8'h0 && $stable(group_req)) [*4]
       |=> active_group == $past(win))
      else $error("held levels did not pick the highest group");
   a_idle_hold: assert property
      ((ce && !any_wr && group_req == 8'h0) [*4] |=> $stable(active_group))
      else $error("active group moved without request");
   a_force_wins: assert property
      (frc_ok [*3] |-> active_group == 3'(fgrp_r - 4'h1))
      else $error("forced group not applied");

   c_force: cover property (frc_ok [*3]);
   c_prio: cover property (live != 8'h0 && win != 3'h0);
   c_read: cover property (psel && penable && !pwrite && pready);
endmodule : sgps_selector_chk

bind sgps_selector sgps_selector_chk u_chk
(
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .group_req(group_req), .active_group(active_group)
);

// *** verif/tb_sgps_selector.sv ***
// Self-checking bench for the group selector over APB and request pins.
// Assumes the request source model and the bound checker.
`timescale 1ns/100ps
`include "sgps_cfg.svh"

module tb_sgps_selector;
   import sgps_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  lvl = 8'h00;
   logic [7:0]  pls = 8'h00;
   wire  [7:0]  group_req;
   sgps_group_t active_group;
   logic [31:0] rdat;
   logic [31:0] t0;
   logic [31:0] t1;
   logic        rerr;
   int          err_count = 0;
   int          checked = 0;

   always #4 pclk = ~pclk;

   sgps_selector #(.EV_AW(4), .TS_W(32)) DUT
   (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .group_req(group_req),
      .active_group(active_group)
   );

   sgps_req_src u_src
   (
      .pclk(pclk), .lvl(lvl), .pls(pls), .group_req(group_req)
   );

   // ======================================================
   // Tasks
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic check(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask : check

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int   n;
      logic hit;
      n   = 0;
      hit = 1'b0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         hit = (pready === 1'b1);
         n++;
      end
      while (!hit && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (!hit)
      begin
         err_count++;
         test_done;
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm, input logic [31:0] m = '1);
      rd(a);
      check(nm, rdat & m, e);
   endtask : rchk

   task automatic agrp(input logic [2:0] e, input string nm);
      check(nm, {29'h0, active_group}, {29'h0, e});
   endtask : agrp

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   task automatic arm(input logic [31:0] r, f);
      int n;
      n = 0;
      wr(`SGPS_A_RISE_EN, r);
      wr(`SGPS_A_FALL_EN, f);
      do
      begin
         rd(`SGPS_A_EVPOP);
         n++;
      end
      while (rdat[0] === 1'b1 && n < 40);
      if (rdat[0] !== 1'b0)
      begin
         err_count++;
         test_done;
      end
   endtask : arm

   task automatic pop(input logic [31:0] n, m, r, f);
      rchk(`SGPS_A_EVPOP, n, "evpop");
      rchk(`SGPS_A_EVRISE, r, "evrise", m);
      rchk(`SGPS_A_EVFALL, f, "evfall", m);
   endtask : pop

   // ======================================================
   // Sequence
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rchk(`SGPS_A_CTRL, 32'h0, "ctrl");
      rchk(`SGPS_A_STATUS, 32'h00010000, "status");
      rchk(`SGPS_A_RISE_EN, 32'h3fffffff, "rise_en");
      rd(8'h40);
      check("unmapped err", {31'h0, rerr}, 32'h1);
      check("unmapped data", rdat, 32'h0);
      agrp(3'h0, "reset group");
      wr(`SGPS_A_CTRL, 32'h7);
      for (int k = 7; k >= 0; k--)
      begin
         lvl <= 8'(8'hff << k);
         cyc(5);
         agrp(3'(k), "held level");
      end
      lvl <= 8'h00;
      cyc(5);
      agrp(3'h0, "no request");
      pls <= 8'h08;
      cyc(1);
      pls <= 8'h00;
      cyc(6);
      agrp(3'h3, "pulse taken");
      cyc(20);
      agrp(3'h3, "pulse kept");
      // Level sweep and pulse overran the sixteen-entry buffer
      rchk(`SGPS_A_STATUS, 32'h08000000, "ovf set", 32'h08000000);
      wr(`SGPS_A_STATUS, 32'h08000000);
      rchk(`SGPS_A_STATUS, 32'h0, "ovf clear", 32'h08000000);
      lvl <= 8'h02;
      arm(32'h20000000, 32'h0);
      agrp(3'h1, "held two");
      wr(`SGPS_A_REMOTE, 32'h5);
      cyc(4);
      agrp(3'h1, "remote blocked");
      pop(32'h3, 32'h20000000, 32'h20000000, 32'h0);
      arm(32'h0, 32'h01000000);
      rd(`SGPS_A_TIME);
      t0 = rdat;
      wr(`SGPS_A_REMOTE, 32'h3);
      rd(`SGPS_A_TIME);
      t1 = rdat;
      pop(32'h3, 32'h01000000, 32'h0, 32'h01000000);
      rd(`SGPS_A_EVTIME);
      check("stamp", {31'h0, rdat > t0 && rdat < t1}, 32'h1);
      lvl <= 8'h00;
      wr(`SGPS_A_CTRL, 32'h1);
      arm(32'h08000000, 32'h0);
      wr(`SGPS_A_REMOTE, 32'h6);
      cyc(4);
      agrp(3'h1, "unused target");
      pop(32'h3, 32'h08000000, 32'h08000000, 32'h0);
      rchk(`SGPS_A_STATUS, 32'h00030001, "status", 32'h00ff0007);
      wr(`SGPS_A_REMOTE, 32'h1);
      cyc(4);
      agrp(3'h0, "remote to one");
      arm(32'h14000000, 32'h0);
      wr(`SGPS_A_CTRL, 32'h29);
      lvl <= 8'h01;
      cyc(5);
      agrp(3'h1, "forced two");
      wr(`SGPS_A_CTRL, 32'h59);
      cyc(4);
      agrp(3'h1, "force unused");
      pop(32'h5, 32'h14000000, 32'h04000000, 32'h0);
      pop(32'h3, 32'h14000000, 32'h10000000, 32'h0);
      wr(`SGPS_A_CTRL, 32'h1);
      cyc(5);
      agrp(3'h0, "force off");
      wr(`SGPS_A_CTRL, 32'h7);
      // Clock enable low: a new level must not move anything
      ce  <= 1'b0;
      lvl <= 8'h10;
      cyc(8);
      agrp(3'h0, "frozen");
      ce <= 1'b1;
      cyc(5);
      agrp(3'h4, "after freeze");
      // Second reset in mid-run
      presetn <= 1'b0;
      cyc(2);
      agrp(3'h0, "in reset");
      presetn <= 1'b1;
      rchk(`SGPS_A_CTRL, 32'h0, "ctrl after reset");
      cyc(4);
      agrp(3'h0, "only one used");
      test_done;
   end
endmodule : tb_sgps_selector
